// ==== verilog/spb_top.v ====
// Serial port buffer, status and frame logic with register port
`timescale 1ns/10ps
`default_nettype none
`include "spb_defs.vh"
// Overview of operation
// - Buffer-empty flag high while transmit buffer empty
// - Empty interrupt requested while flag and enables set
// - Data write loads buffer, clears empty flag
// - Complete flag sets when shifter and buffer empty
// - Complete clears on acknowledge or writing one
// - Complete interrupt requested when flag set, enabled
// - Parity bit sent after data, before stop
// - Transmit disable waits for shifter and buffer empty
// - Receive enable selects input; sync uses external clock
// - Shift bits to first stop, then store
// - Unused upper data bits read as zero
// - Ninth bit and errors stored per frame
// - Receive flag shows unread data; disable flushes
// - Receive interrupt while flag set; read clears
// - Error flags read-only, never interrupt
// - Frame error reflects first stop bit only
// - Overrun when full, shifter full, new start
// - Overrun clears on successful store
// - Checker compares parity, stores mismatch per frame
// - Parity error zero when checking disabled
// - Even parity is xor, odd inverted
// - Buffer moves to shifter when idle or done
// - Frame is start, data, parity, stops; idle high
module spb_top (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Register port
  input wire [`SPB_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Bit-rate timing and interrupt context
  input wire baud_tick_i,
  input wire ext_transfer_clock_pin_i,
  input wire global_irq_en_i,
  input wire txc_irq_ack_i,
  // Serial pins
  input wire serial_in_pin_i,
  output reg serial_out_pin_o,
  output reg serial_out_oe_n_o,
  // Interrupt requests
  output reg tx_empty_irq_o,
  output reg tx_complete_irq_o,
  output reg rx_complete_irq_o
);
  localparam T_IDLE = 3'b001;
  localparam T_SHIFT = 3'b010;
  localparam T_DONE = 3'b100;
  // Software-written control and format
  reg [7:0] ctrl_q;
  reg [7:0] fmt_q;
  // Transmit side
  reg [8:0] txbuf_q; // Transmit buffer with ninth bit
  reg txfull_q; // Buffer holds data not yet in the shifter
  reg [11:0] txsh_q; // Frame bits still to send, LSB first
  reg [3:0] txcnt_q; // Bits left in the frame
  reg [2:0] tst_q; // One-hot transmitter state
  reg txc_q; // Transmit complete flag
  reg txon_q; // Transmitter owns the output pin
  // Receive FIFO, two entries of {perr, ovr, ferr, data9}
  reg [11:0] fifo_q [0:`SPB_FIFO_DEPTH-1];
  reg [1:0] fcnt_q; // Entries held
  reg rdptr_q; // Oldest entry
  reg pend_q; // Complete frame parked in the shifter
  reg [11:0] pend_val_q; // Parked frame, awaiting a free slot
  reg ovr_q; // Overrun seen, tagged on the next stored frame
  reg xck_q; // Previous external clock level
  // Receiver outputs
  wire rx_start;
  wire rx_done;
  wire [8:0] rx_data;
  wire rx_ferr;
  wire rx_perr;
  wire tick;
  wire [3:0] nbits;
  wire rxen;
  wire tx_enable_bit;
  wire [11:0] head;
  wire wr_data;
  wire rd_data;
  wire tx_tick;
  wire tx_load;
  wire tx_par; // Parity of the buffered character, odd-select applied
  // Data bits per character from the size code
  function [3:0] spb_nbits;
    input [2:0] csz;
    begin
      if (csz == `SPB_CSZ_NINE) begin
        spb_nbits = 4'd9;
      end else if (csz[2]) begin
        spb_nbits = 4'd8; // Reserved codes behave as eight bits
      end else begin
        spb_nbits = 4'd5 + {2'b00, csz[1:0]};
      end
    end
  endfunction
  assign nbits = spb_nbits({ctrl_q[`SPB_CT_CSZ2], fmt_q[`SPB_FM_CSZ1], fmt_q[`SPB_FM_CSZ0]});
  assign rxen = ctrl_q[`SPB_CT_RXEN];
  assign tx_enable_bit = ctrl_q[`SPB_CT_TX_ENABLE_BIT];
  // Sync mode clocks on rising external clock, else the bit-rate tick
  assign tick = fmt_q[`SPB_FM_SYNC] ? (ext_transfer_clock_pin_i & ~xck_q) : baud_tick_i;
  assign head = fifo_q[rdptr_q];
  assign wr_data = wr_i && addr_i == `SPB_ADDR_DATA;
  assign rd_data = rd_i && addr_i == `SPB_ADDR_DATA && fcnt_q != 2'd0;
  assign tx_tick = tick;
  // Bits above the character size are ignored, so they never leak into parity
  assign tx_par = ^(txbuf_q & ~(9'h1ff << nbits)) ^ fmt_q[`SPB_FM_PODD];
  // Shifter takes the buffer when idle or right after the last stop bit
  assign tx_load = txfull_q && tx_tick && (tst_q != T_SHIFT || txcnt_q == 4'h1);
  spb_rx u_rx (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .enable_i(rxen),
    .tick_i(tick),
    .nbits_i(nbits),
    .par_en_i(fmt_q[`SPB_FM_PEN]),
    .par_odd_i(fmt_q[`SPB_FM_PODD]),
    .line_i(serial_in_pin_i),
    .start_o(rx_start),
    .done_o(rx_done),
    .data_o(rx_data),
    .ferr_o(rx_ferr),
    .perr_o(rx_perr)
  );
  // Register writes; the ninth transmit bit lives in control
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= `SPB_CTRL_RST;
      fmt_q <= `SPB_FMT_RST;
      xck_q <= 1'b0;
    end else begin
      xck_q <= ext_transfer_clock_pin_i;
      if (wr_i && addr_i == `SPB_ADDR_CTRL) begin
        // Received ninth bit is FIFO state, not writable
        ctrl_q <= {wdata_i[7:2], ctrl_q[`SPB_CT_RX9], wdata_i[`SPB_CT_TX9]};
      end
      if (wr_i && addr_i == `SPB_ADDR_FMT) begin
        fmt_q <= wdata_i;
      end
    end
  end
  // Transmit buffer, shifter and complete flag
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txbuf_q <= 9'h000;
      txfull_q <= 1'b0;
      txsh_q <= 12'hfff;
      txcnt_q <= 4'h0;
      tst_q <= T_IDLE;
      txc_q <= 1'b0;
      txon_q <= 1'b0;
    end else begin
      if (tx_load) begin
        // Frame: start low, data, optional parity, stops high
        // Unused data bits are masked so stops and parity are never overwritten
        txsh_q <= (({3'b000, txbuf_q} & ~(12'hfff << nbits)) << 1) |
          ((12'hfff << (nbits + 4'h1)) &
          ~({11'h000, fmt_q[`SPB_FM_PEN] & ~tx_par} << (nbits + 4'h1)));
        txcnt_q <= nbits + 4'd2 + {3'b000, fmt_q[`SPB_FM_PEN]} + {3'b000, fmt_q[`SPB_FM_STOP2]};
        tst_q <= T_SHIFT;
        txfull_q <= 1'b0;
      end else if (tx_tick && tst_q == T_SHIFT) begin
        txsh_q <= {1'b1, txsh_q[11:1]};
        txcnt_q <= txcnt_q - 4'h1;
        if (txcnt_q == 4'h1) begin
          tst_q <= T_DONE;
        end
      end else if (tst_q == T_DONE) begin
        tst_q <= T_IDLE;
      end
      if (wr_data && tx_enable_bit) begin
        txbuf_q <= {ctrl_q[`SPB_CT_TX9], wdata_i};
        txfull_q <= 1'b1;
      end
      // Set wins over a clear in the same cycle
      if (tst_q == T_DONE && !txfull_q) begin
        txc_q <= 1'b1;
      end else if (txc_irq_ack_i ||
                   (wr_i && addr_i == `SPB_ADDR_STATUS && wdata_i[`SPB_ST_TXC])) begin
        txc_q <= 1'b0;
      end
      // Pin released only once nothing is left to send
      if (tx_enable_bit) begin
        txon_q <= 1'b1;
      end else if (!txfull_q && tst_q == T_IDLE) begin
        txon_q <= 1'b0;
      end
    end
  end
  // Receive FIFO, overrun tracking and flush
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fifo_q[0] <= 12'h000;
      fifo_q[1] <= 12'h000;
      fcnt_q <= 2'd0;
      rdptr_q <= 1'b0;
      pend_q <= 1'b0;
      pend_val_q <= 12'h000;
      ovr_q <= 1'b0;
    end else if (!rxen) begin
      fcnt_q <= 2'd0;
      pend_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      // Space freed by a read this cycle lets the parked frame in
      if (rd_data) begin
        rdptr_q <= ~rdptr_q;
      end
      if (rx_start && pend_q && fcnt_q == 2'd2 && !rd_data) begin
        ovr_q <= 1'b1;
        pend_q <= 1'b0; // Parked frame is lost to the new one
      end
      if (rx_done) begin
        pend_q <= 1'b1;
        pend_val_q <= {rx_perr, 1'b0, rx_ferr, rx_data};
      end
      if (pend_q && !rx_done && (fcnt_q != 2'd2 || rd_data) &&
          !(rx_start && fcnt_q == 2'd2 && !rd_data)) begin
        fifo_q[rdptr_q ^ fcnt_q[0]] <= pend_val_q | {2'b00, ovr_q, 9'h000} << 1;
        ovr_q <= 1'b0;
        pend_q <= 1'b0;
        fcnt_q <= rd_data ? fcnt_q : fcnt_q + 2'd1;
      end else if (rd_data) begin
        fcnt_q <= fcnt_q - 2'd1;
      end
    end
  end
  // Read data, pins and interrupt requests, all registered
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      serial_out_pin_o <= 1'b1;
      serial_out_oe_n_o <= 1'b1;
      tx_empty_irq_o <= 1'b0;
      tx_complete_irq_o <= 1'b0;
      rx_complete_irq_o <= 1'b0;
    end else begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `SPB_ADDR_DATA: rdata_o <= (fcnt_q != 2'd0) ? head[7:0] : 8'h00;
          `SPB_ADDR_STATUS: rdata_o <= {fcnt_q != 2'd0, txc_q, ~txfull_q,
            head[9] & (fcnt_q != 2'd0), head[10] & (fcnt_q != 2'd0),
            head[11] & (fcnt_q != 2'd0), 2'b00};
          `SPB_ADDR_CTRL: rdata_o <= {ctrl_q[7:2], head[8] & (fcnt_q != 2'd0),
            ctrl_q[`SPB_CT_TX9]};
          `SPB_ADDR_FMT: rdata_o <= fmt_q;
          default: rdata_o <= 8'h00;
        endcase
      end
      // Idle line high; pin released when transmitter is off
      serial_out_pin_o <= (tst_q == T_SHIFT) ? txsh_q[0] : 1'b1;
      serial_out_oe_n_o <= ~txon_q;
      tx_empty_irq_o <= global_irq_en_i & ctrl_q[`SPB_CT_TXEIE] & ~txfull_q;
      tx_complete_irq_o <= global_irq_en_i & ctrl_q[`SPB_CT_TXCIE] & txc_q;
      rx_complete_irq_o <= global_irq_en_i & ctrl_q[`SPB_CT_RXCIE] & (fcnt_q != 2'd0);
    end
  end
endmodule // spb_top
`default_nettype wire

// ==== verilog/spb_defs.vh ====
// Constants for the serial port buffer and status logic
`ifndef SPB_DEFS_VH
`define SPB_DEFS_VH
// Register addresses on the plain port
`define SPB_ADDR_W 2
`define SPB_ADDR_DATA 2'h0
`define SPB_ADDR_STATUS 2'h1
`define SPB_ADDR_CTRL 2'h2
`define SPB_ADDR_FMT 2'h3
// Status register bit positions
`define SPB_ST_PERR 2
`define SPB_ST_OVR 3
`define SPB_ST_FERR 4
`define SPB_ST_TXE 5
`define SPB_ST_TXC 6
`define SPB_ST_RXC 7
// Control register bit positions
`define SPB_CT_TX9 0
`define SPB_CT_RX9 1
`define SPB_CT_CSZ2 2
`define SPB_CT_TX_ENABLE_BIT 3
`define SPB_CT_RXEN 4
`define SPB_CT_TXEIE 5
`define SPB_CT_TXCIE 6
`define SPB_CT_RXCIE 7
// Frame format register bit positions
`define SPB_FM_CSZ0 1
`define SPB_FM_CSZ1 2
`define SPB_FM_STOP2 3
`define SPB_FM_PODD 4
`define SPB_FM_PEN 5
`define SPB_FM_SYNC 6
// Reset values
`define SPB_CTRL_RST 8'h00
`define SPB_FMT_RST 8'h06
// Character size code for nine data bits
`define SPB_CSZ_NINE 3'h7
// Receive FIFO depth
`define SPB_FIFO_DEPTH 2
`endif

// ==== verilog/spb_rx.v ====
// Receive shifter: samples one bit per receive tick and assembles a frame
`timescale 1ns/10ps
`default_nettype none
`include "spb_defs.vh"
module spb_rx (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Control
  input wire enable_i,
  input wire tick_i,
  input wire [3:0] nbits_i,
  input wire par_en_i,
  input wire par_odd_i,
  input wire line_i,
  // Frame out
  output reg start_o,
  output reg done_o,
  output reg [8:0] data_o,
  output reg ferr_o,
  output reg perr_o
);
  localparam S_IDLE = 3'b001;
  localparam S_DATA = 3'b010;
  localparam S_STOP = 3'b100;
  reg [2:0] st_q; // One-hot state
  reg [3:0] cnt_q; // Bits still expected in this phase
  reg [8:0] sh_q; // Shift register, LSB first
  reg par_q; // Running xor of data bits
  reg has_par_q; // Parity bit still to come
  // Bit-level sequencer; start bit is taken on a single low sample
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 9'h000;
      par_q <= 1'b0;
      has_par_q <= 1'b0;
      start_o <= 1'b0;
      done_o <= 1'b0;
      data_o <= 9'h000;
      ferr_o <= 1'b0;
      perr_o <= 1'b0;
    end else begin
      start_o <= 1'b0;
      done_o <= 1'b0;
      if (!enable_i) begin
        // Disable is immediate, a frame in flight is dropped
        st_q <= S_IDLE;
      end else if (tick_i) begin
        case (st_q)
          // After the first stop a new start may follow on the very next tick
          S_IDLE, S_STOP: begin
            if (!line_i) begin
              st_q <= S_DATA;
              cnt_q <= nbits_i;
              sh_q <= 9'h000;
              par_q <= 1'b0;
              has_par_q <= par_en_i;
              start_o <= 1'b1;
            end
          end
          S_DATA: begin
            if (cnt_q != 4'h0) begin
              sh_q <= {line_i, sh_q[8:1]};
              par_q <= par_q ^ line_i;
              cnt_q <= cnt_q - 4'h1;
            end else if (has_par_q) begin
              // Mismatch of received bit against computed parity
              perr_o <= (par_q ^ par_odd_i) ^ line_i;
              has_par_q <= 1'b0;
            end else begin
              st_q <= S_STOP;
            end
            if (cnt_q == 4'h0 && !has_par_q) begin
              // First stop bit sampled now; a second is never waited for
              ferr_o <= ~line_i;
              data_o <= sh_q >> (4'd9 - nbits_i);
              done_o <= 1'b1;
              if (!par_en_i) begin
                perr_o <= 1'b0;
              end
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // spb_rx
`default_nettype wire

// ==== test/spb_top_props.sv ====
// Port checker of the serial port block
`timescale 1ns/10ps
`default_nettype none
`include "spb_defs.vh"
module spb_top_props (
  // Clock, reset, register port
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Context
  input wire logic baud_tick_i,
  input wire logic global_irq_en_i,
  input wire logic txc_irq_ack_i,
  // Pins and requests
  input wire logic serial_out_pin_o,
  input wire logic serial_out_oe_n_o,
  input wire logic tx_empty_irq_o,
  input wire logic tx_complete_irq_o,
  input wire logic rx_complete_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Ack in the third of three tick-free cycles, so no frame can set the flag again
  sequence s_quiet;
    !baud_tick_i ##1 !baud_tick_i ##1 (txc_irq_ack_i && !baud_tick_i);
  endsequence
  property p_gie_e; !global_irq_en_i |=> !tx_empty_irq_o; endproperty
  a_gie_e: assert property (p_gie_e) else $error("empty irq masked");
  property p_gie_c; !global_irq_en_i |=> !tx_complete_irq_o; endproperty
  a_gie_c: assert property (p_gie_c) else $error("complete irq masked");
  property p_gie_r; !global_irq_en_i |=> !rx_complete_irq_o; endproperty
  a_gie_r: assert property (p_gie_r) else $error("rx irq masked");
  property p_rd0; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
  property p_oe; $rose(serial_out_oe_n_o) |-> serial_out_pin_o; endproperty
  a_oe: assert property (p_oe) else $error("released mid frame");
  property p_bit;
    $changed(serial_out_pin_o) |-> $past(baud_tick_i) || $past(baud_tick_i, 2);
  endproperty
  a_bit: assert property (p_bit) else $error("line moved off tick");
  property p_flush;
    wr_i && addr_i == `SPB_ADDR_CTRL && !wdata_i[`SPB_CT_RXEN] |-> ##3 !rx_complete_irq_o;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_ack; s_quiet |-> ##2 !tx_complete_irq_o; endproperty
  a_ack: assert property (p_ack) else $error("ack kept flag");
endmodule // spb_top_props
`default_nettype wire

// ==== test/spb_far_end.sv ====
// Remote serial party: sends frames, captures frames, one bit per tick
`timescale 1ns/10ps
`default_nettype none
module spb_far_end (
  input wire logic clk_i,
  input wire logic tick_i,
  input wire logic line_out_i,
  input wire logic oe_n_i,
  output logic line_in_o
);
  int nb = 8, pen = 0, cnt = -1, acc;
  int rxq[$];
  initial line_in_o = 1'b1;
  // Capture data, parity and first stop after a driven low start
  always @(posedge clk_i) if (tick_i) begin
    if (cnt < 0) begin
      if (!oe_n_i && !line_out_i) cnt = 0;
      acc = 0;
    end else begin
      acc = acc | (int'(line_out_i) << cnt);
      cnt = cnt + 1;
      if (cnt == nb + pen + 1) begin
        rxq.push_back(acc);
        cnt = -1;
      end
    end
  end
  // Send n bits LSB first, then rest at idle high
  task automatic send(input int bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i iff tick_i);
      line_in_o <= bits[i];
    end
    @(posedge clk_i iff tick_i);
    line_in_o <= 1'b1;
  endtask
endmodule // spb_far_end
`default_nettype wire

// ==== test/spb_tb_top.sv ====
// Self-checking bench of the serial port block
`timescale 1ns/10ps
`default_nettype none
`include "spb_defs.vh"
module spb_tb_top;
  logic clk_i, nrst_i, wr_i, rd_i, txc_irq_ack_i, serial_in_pin_i;
  logic baud_tick_i = 0, global_irq_en_i = 1, ext_transfer_clock_pin_i = 0;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v, f;
  logic serial_out_pin_o, serial_out_oe_n_o;
  logic tx_empty_irq_o, tx_complete_irq_o, rx_complete_irq_o;
  logic [7:0] fm [7] = '{8'h06, 8'h26, 8'h36, 8'h3e, 8'h00, 8'h24, 8'h06};
  bit [31:0] seed = 31783;
  int err_count, cmp_count, nb, pen, odd, d, fe, pe, q[$];
  spb_top uut (.*);
  spb_far_end far (.clk_i, .tick_i(baud_tick_i), .line_out_i(serial_out_pin_o),
    .oe_n_i(serial_out_oe_n_o), .line_in_o(serial_in_pin_i));
  // Clock; bit tick on every fourth cycle
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) baud_tick_i <= ($time / 10) % 4 == 2;
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected parity: xor of data bits, inverted for odd
  function automatic int par(input int x);
    return (^(x & ((1 << nb) - 1))) ^ odd;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] w);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
  initial begin
    {nrst_i, wr_i, rd_i, txc_irq_ack_i, addr_i, wdata_i} = 0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1;
    rd(`SPB_ADDR_CTRL);
    chk(v, `SPB_CTRL_RST);
    rd(`SPB_ADDR_FMT);
    chk(v, `SPB_FMT_RST);
    wr(`SPB_ADDR_CTRL, 8'hf8);
    for (int k = 0; k < 7; k++) begin
      f = fm[k];
      nb = k == 6 ? 9 : 5 + f[2:1];
      pen = f[5];
      odd = f[4];
      far.nb = nb;
      far.pen = pen;
      wr(`SPB_ADDR_FMT, f);
      // Two characters back to back; second waits in the buffer
      for (int j = 0; j < 2; j++) begin
        d = rnd() & ((1 << nb) - 1);
        q.push_back(d);
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 200 && !tx_empty_irq_o; i++) @(posedge clk_i);
        #1 chk(tx_empty_irq_o, 1);
        wr(`SPB_ADDR_CTRL, 8'hf8 | (k == 6 ? 8'h04 : 8'h00) | d[8]);
        wr(`SPB_ADDR_DATA, d[7:0]);
      end
      repeat (2) @(posedge clk_i);
      #1 chk(tx_empty_irq_o, 0);
      for (int j = 0; j < 2; j++) begin
        for (int i = 0; i < 200 && far.rxq.size() == 0; i++) @(posedge clk_i);
        d = q.pop_front();
        chk(far.rxq.pop_front(), d | (pen ? par(d) : 0) << nb | 1 << nb + pen);
      end
      for (int i = 0; i < 200 && !tx_complete_irq_o; i++) @(posedge clk_i);
      #1 chk(tx_complete_irq_o, 1);
      if (k % 2) begin
        @(posedge clk_i iff baud_tick_i);
        repeat (2) @(posedge clk_i);
        txc_irq_ack_i <= 1;
        @(posedge clk_i);
        txc_irq_ack_i <= 0;
      end else wr(`SPB_ADDR_STATUS, 8'h40);
      repeat (2) @(posedge clk_i);
      #1 chk(tx_complete_irq_o, 0);
      // One received frame, with a bad parity or stop in two cases
      d = rnd() & ((1 << nb) - 1);
      pe = k == 2;
      fe = k == 3;
      far.send(d << 1 | (pen ? par(d) ^ pe : 0) << nb + 1 | (fe ? 0 : 1) << nb + 1 + pen,
        nb + pen + 2);
      for (int i = 0; i < 200 && !rx_complete_irq_o; i++) @(posedge clk_i);
      #1 chk(rx_complete_irq_o, 1);
      wr(`SPB_ADDR_STATUS, 8'h00);
      rd(`SPB_ADDR_STATUS);
      chk(v & 8'h9c, 8'h80 | fe << 4 | pe << 2);
      rd(`SPB_ADDR_CTRL);
      if (nb == 9) chk(v[1], d[8]);
      rd(`SPB_ADDR_DATA);
      chk(v, d[7:0]);
      rd(`SPB_ADDR_STATUS);
      chk(v[7], 0);
    end
    @(posedge clk_i);
    global_irq_en_i <= 0;
    repeat (2) @(posedge clk_i);
    #1 chk(tx_empty_irq_o, 0);
    global_irq_en_i <= 1;
    // Four unread frames: third parked, start of fourth overruns it
    for (int j = 0; j < 4; j++) begin
      q.push_back(rnd() & 9'h1ff);
      far.send(q[j] << 1 | 1 << 10, 11);
    end
    repeat (8) @(posedge clk_i);
    for (int j = 0; j < 3; j++) begin
      rd(`SPB_ADDR_STATUS);
      chk(v & 8'h88, j == 2 ? 8'h88 : 8'h80);
      rd(`SPB_ADDR_DATA);
      chk(v, q[j == 2 ? 3 : j] & 8'hff);
    end
    q.delete();
    // Unread frame flushed by receive disable
    far.send(d << 1 | 1 << nb + 1, nb + 2);
    for (int i = 0; i < 200 && !rx_complete_irq_o; i++) @(posedge clk_i);
    wr(`SPB_ADDR_CTRL, 8'h08);
    rd(`SPB_ADDR_STATUS);
    chk(v[7], 0);
    // Disable with a character pending keeps driving until sent
    far.nb = 8;
    wr(`SPB_ADDR_DATA, 8'h55);
    wr(`SPB_ADDR_CTRL, 8'h00);
    #1 chk(serial_out_oe_n_o, 0);
    for (int i = 0; i < 200 && far.rxq.size() == 0; i++) @(posedge clk_i);
    chk(far.rxq.pop_front(), 16'h155);
    for (int i = 0; i < 100 && !serial_out_oe_n_o; i++) @(posedge clk_i);
    #1 chk(serial_out_oe_n_o, 1);
    stop_test();
  end
endmodule // spb_tb_top
bind spb_top spb_top_props chk_i (.*);
`default_nettype wire
